// file: pll_clock_source_routing_config_test.sv
`timescale 1ns/1ps
module pll_clock_source_routing_config_test
   import pll_route_pkg::*;
;
   // ************************************************************
   // signals and instance
   // ************************************************************
   localparam int         CLEN     = 4;      // short calibration keeps the run brief
   localparam logic [9:0] IDX_NONE = 10'h011;
   logic              CORE_CLK = 1'b0;
   logic              NRST     = 1'b0;
   logic [ADDR_W-1:0] AWADDR   = '0;
   logic [ADDR_W-1:0] ARADDR   = '0;
   logic              AWVALID  = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic [31:0]       WDATA    = '0;
   logic [3:0]        WSTRB    = '0;
   logic              AWREADY, WREADY, BVALID, ARREADY, RVALID, PLL_ON, PLL_ASYNC_PD;
   logic              PFD_NEG_POL, SRC_VCO, DIV_BYPASS, CAL_START, CAL_BUSY;
   logic [1:0]        BRESP, RRESP, resp;
   logic [31:0]       RDATA, rdat;
   logic [2:0]        DIV_RATIO;
   int                bad_count = 0, n_compared = 0, cal_cnt = 0;

   pll_route_ctrl #(.CAL_LEN(CLEN)) dut (
      .CORE_CLK(CORE_CLK), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .PLL_ON(PLL_ON),
      .PLL_ASYNC_PD(PLL_ASYNC_PD), .PFD_NEG_POL(PFD_NEG_POL), .SRC_VCO(SRC_VCO),
      .DIV_BYPASS(DIV_BYPASS), .DIV_RATIO(DIV_RATIO), .CAL_START(CAL_START), .CAL_BUSY(CAL_BUSY));

   // clock and a pulse counter; counting cycles high also proves one-cycle pulses
   always #5 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK)
   begin
      if (CAL_START === 1'b1)
         cal_cnt <= cal_cnt + 1;
   end

   // ************************************************************
   // bus tasks and comparisons
   // ************************************************************
   task results;
   begin
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
   begin
      n_compared++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   end
   endtask

   // a hung handshake counts as a mismatch and ends the run
   task tmo(input int n, input int lim);
   begin
      if (n >= lim)
      begin
         $display("CHECK FAILED handshake expected 1 seen timeout");
         bad_count++;
         results();
      end
   end
   endtask

   task wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
      int   n;
      logic aw_ok;
      logic w_ok;
   begin
      @(posedge CORE_CLK);
      AWADDR  <= {idx, 2'b00};
      AWVALID <= 1'b1;
      WDATA   <= {24'h0, d};
      WSTRB   <= 4'hf;
      WVALID  <= 1'b1;
      BREADY  <= 1'b1;
      n       = 0;
      aw_ok   = 1'b0;
      w_ok    = 1'b0;
      // each channel is released at the edge that takes it
      while (!(aw_ok && w_ok) && n < 20)
      begin
         @(posedge CORE_CLK);
         n++;
         if (!aw_ok && AWREADY === 1'b1)
         begin
            aw_ok   = 1'b1;
            AWVALID <= 1'b0;
         end
         if (!w_ok && WREADY === 1'b1)
         begin
            w_ok   = 1'b1;
            WVALID <= 1'b0;
         end
      end
      tmo(n, 20);
      do
      begin
         @(posedge CORE_CLK);
         n++;
      end
      while (BVALID !== 1'b1 && n < 40);
      tmo(n, 40);
      r      = BRESP;
      BREADY <= 1'b0;
   end
   endtask

   task rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
      int n;
   begin
      @(posedge CORE_CLK);
      ARADDR  <= {idx, 2'b00};
      ARVALID <= 1'b1;
      RREADY  <= 1'b1;
      n       = 0;
      do
      begin
         @(posedge CORE_CLK);
         n++;
      end
      while (ARREADY !== 1'b1 && n < 20);
      tmo(n, 20);
      ARVALID <= 1'b0;
      do
      begin
         @(posedge CORE_CLK);
         n++;
      end
      while (RVALID !== 1'b1 && n < 40);
      tmo(n, 40);
      d      = RDATA;
      r      = RRESP;
      RREADY <= 1'b0;
   end
   endtask

   task rchk(input logic [9:0] idx, input logic [31:0] exp);
   begin
      rd(idx, rdat, resp);
      chk("read data", exp, rdat);
      chk("read resp", {30'h0, RESP_OKAY}, {30'h0, resp});
   end
   endtask

   // commit and let the active settings land before looking
   task commit;
   begin
      wr(IDX_UPDATE, UPDATE_CMD, resp);
      chk("update resp", {30'h0, RESP_OKAY}, {30'h0, resp});
      @(posedge CORE_CLK);
   end
   endtask

   task ochk(input logic [7:0] exp);
   begin
      chk("outputs", {24'h0, exp}, {24'h0, PLL_ON, PLL_ASYNC_PD, PFD_NEG_POL, SRC_VCO,
          DIV_BYPASS, DIV_RATIO});
   end
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      repeat (12) @(posedge CORE_CLK);
      NRST <= 1'b1;
      ochk({5'b01000, 3'd4});
      rchk(IDX_PWR_POL, 32'h01); rchk(IDX_CAL_CTRL, 32'h00);
      rchk(IDX_DIV_RATIO, 32'h02); rchk(IDX_SRC_SEL, 32'h00);
      // staged values read back but stay inert until a proper commit
      wr(IDX_PWR_POL, 8'h80, resp); wr(IDX_DIV_RATIO, 8'h04, resp);
      wr(IDX_SRC_SEL, 8'h02, resp);
      rchk(IDX_PWR_POL, 32'h80);
      ochk({5'b01000, 3'd4});
      wr(IDX_UPDATE, 8'h02, resp);
      repeat (3) @(posedge CORE_CLK);
      ochk({5'b01000, 3'd4});
      commit();
      ochk({5'b10110, 3'd6});
      rchk(IDX_STATUS, 32'h0);
      // every documented divider code, zero through four, giving ratios two through six
      for (int c = 0; c < 5; c++)
      begin
         wr(IDX_DIV_RATIO, 8'(c), resp);
         commit();
         chk("ratio", 32'(c + 2), {29'h0, DIV_RATIO});
      end
      wr(IDX_SRC_SEL, 8'h01, resp); wr(IDX_PWR_POL, 8'h01, resp);
      commit();
      ochk({5'b01001, 3'd6});
      // slow external oscillator: PLL on with the divider bypassed
      wr(IDX_PWR_POL, 8'h00, resp);
      commit();
      ochk({5'b10001, 3'd6});
      // reserved power code leaves the PLL neither running nor powered down
      wr(IDX_PWR_POL, 8'h02, resp);
      commit();
      ochk({5'b00001, 3'd6});
      wr(IDX_NONE, 8'h55, resp);
      chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
      rd(IDX_NONE, rdat, resp);
      chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
      chk("unmapped data", 32'h0, rdat);
      // calibration runs with the VCO as source and its divider toggling in the path
      wr(IDX_SRC_SEL, 8'h02, resp); wr(IDX_PWR_POL, 8'h00, resp);
      // calibration starts only on a committed set, and needs clear plus commit to re-arm
      wr(IDX_CAL_CTRL, 8'h01, resp);
      repeat (3) @(posedge CORE_CLK);
      chk("cal starts", 32'(0), 32'(cal_cnt));
      commit();
      chk("cal busy", 32'h1, {31'h0, CAL_BUSY});
      ochk({5'b10010, 3'd6});
      repeat (CLEN + 4) @(posedge CORE_CLK);
      chk("cal starts", 32'(1), 32'(cal_cnt));
      rchk(IDX_STATUS, 32'h2);
      commit();
      repeat (3) @(posedge CORE_CLK);
      chk("cal starts", 32'(1), 32'(cal_cnt));
      wr(IDX_CAL_CTRL, 8'h00, resp);
      commit();
      wr(IDX_CAL_CTRL, 8'h01, resp);
      commit();
      repeat (CLEN + 4) @(posedge CORE_CLK);
      chk("cal starts", 32'(2), 32'(cal_cnt));
      results();
   end
endmodule

// file: pll_route_ctrl.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module pll_route_ctrl
   import pll_route_pkg::*;
#(
   parameter int CAL_LEN = CAL_CYCLES
)(
   input  wire logic              CORE_CLK,
   input  wire logic              NRST,
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   output logic [1:0]             BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   output logic [31:0]            RDATA,
   output logic [1:0]             RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY,
   output logic                   PLL_ON,
   output logic                   PLL_ASYNC_PD,
   output logic                   PFD_NEG_POL,
   output logic                   SRC_VCO,
   output logic                   DIV_BYPASS,
   output logic [2:0]             DIV_RATIO,
   output logic                   CAL_START,
   output logic                   CAL_BUSY
);

   // ************************************************************
   // bus handshakes
   // ************************************************************
   ctrl_t             stg_q;
   ctrl_t             act_q;
   logic              upd_q;
   logic              cal_done_q;
   logic [15:0]       cal_cnt_q;
   logic              seen_upd_q;

   // address and data are taken together, one transfer in flight
   wire               wr_go    = AWVALID & WVALID & ~AWREADY & ~BVALID;
   wire               wr_fire  = AWREADY & AWVALID & WVALID;
   wire               rd_go    = ARVALID & ~ARREADY & ~RVALID;
   wire               rd_fire  = ARREADY & ARVALID;
   wire               wlane    = wr_fire & WSTRB[0];
   wire [9:0]         widx     = AWADDR[ADDR_W-1:2];
   wire [9:0]         ridx     = ARADDR[ADDR_W-1:2];
   wire [7:0]         wb       = WDATA[7:0];

   // write decode
   wire               w_pwr    = wlane & (widx == IDX_PWR_POL);
   wire               w_cal    = wlane & (widx == IDX_CAL_CTRL);
   wire               w_div    = wlane & (widx == IDX_DIV_RATIO);
   wire               w_src    = wlane & (widx == IDX_SRC_SEL);
   wire               w_upd    = wlane & (widx == IDX_UPDATE) & (wb == UPDATE_CMD);
   wire               w_hit    = (widx == IDX_PWR_POL) | (widx == IDX_CAL_CTRL)
                               | (widx == IDX_DIV_RATIO) | (widx == IDX_SRC_SEL)
                               | (widx == IDX_UPDATE) | (widx == IDX_STATUS);

   // read selection shows staged values plus live status
   wire               r_hit    = (ridx == IDX_PWR_POL) | (ridx == IDX_CAL_CTRL)
                               | (ridx == IDX_DIV_RATIO) | (ridx == IDX_SRC_SEL)
                               | (ridx == IDX_UPDATE) | (ridx == IDX_STATUS);
   wire [7:0]         r_byte   =
        (ridx == IDX_PWR_POL)   ? {stg_q.pfd_neg, 5'h00, stg_q.pwr} :
        (ridx == IDX_CAL_CTRL)  ? {7'h00, stg_q.cal} :
        (ridx == IDX_DIV_RATIO) ? {5'h00, stg_q.div} :
        (ridx == IDX_SRC_SEL)   ? {6'h00, stg_q.src_vco, stg_q.bypass} :
        (ridx == IDX_UPDATE)    ? {7'h00, upd_q} :
        (ridx == IDX_STATUS)    ? {5'h00, upd_q, cal_done_q, CAL_BUSY} : 8'h00;

   // staged next value; unwritten fields keep their contents
   ctrl_t             stg_d;
   always_comb
   begin
      stg_d = stg_q;
      if (w_pwr)
      begin
         stg_d.pfd_neg = wb[7];
         stg_d.pwr     = wb[1:0];
      end
      if (w_cal)
         stg_d.cal = wb[0];
      if (w_div)
         stg_d.div = wb[2:0];
      if (w_src)
      begin
         stg_d.src_vco = wb[1];
         stg_d.bypass  = wb[0];
      end
   end

   // write channel: ready pulses for one cycle, response follows
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         AWREADY <= 1'b0;
         WREADY  <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= RESP_OKAY;
      end
      else
      begin
         AWREADY <= wr_go;
         WREADY  <= wr_go;
         if (wr_fire)
         begin
            BVALID <= 1'b1;
            BRESP  <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (BREADY)
            BVALID <= 1'b0;
      end
   end

   // read channel
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= RESP_OKAY;
      end
      else
      begin
         ARREADY <= rd_go;
         if (rd_fire)
         begin
            RVALID <= 1'b1;
            RDATA  <= {24'h00_0000, r_byte};
            RRESP  <= r_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (RREADY)
            RVALID <= 1'b0;
      end
   end

   // ************************************************************
   // staging, commit and active outputs
   // ************************************************************
   // a launch needs the committed bit to go from clear to set, so a
   // bit left set by an earlier commit never relaunches
   wire               cal_rise = upd_q & stg_q.cal & ~act_q.cal;
   wire [15:0]        cal_len  = 16'(CAL_LEN);

   // staged copy and update flag; a fresh update write wins over self-clear
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         stg_q      <= CTRL_RST;
         upd_q      <= 1'b0;
         seen_upd_q <= 1'b0;
      end
      else
      begin
         stg_q      <= stg_d;
         upd_q      <= w_upd;
         seen_upd_q <= seen_upd_q | upd_q;
      end
   end

   // active copy moves as a whole only while the update flag stands
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         act_q        <= CTRL_RST;
         PLL_ON       <= 1'b0;
         PLL_ASYNC_PD <= 1'b1;
         PFD_NEG_POL  <= 1'b0;
         SRC_VCO      <= 1'b0;
         DIV_BYPASS   <= 1'b0;
         DIV_RATIO    <= DIV_RST + DIV_OFFSET;
      end
      else if (upd_q)
      begin
         act_q        <= stg_q;
         PLL_ON       <= (stg_q.pwr == PWR_NORMAL);
         PLL_ASYNC_PD <= (stg_q.pwr == PWR_ASYNC_PD);
         PFD_NEG_POL  <= stg_q.pfd_neg;
         SRC_VCO      <= stg_q.src_vco;
         DIV_BYPASS   <= stg_q.bypass;
         DIV_RATIO    <= stg_q.div + DIV_OFFSET;
      end
   end

   // ************************************************************
   // calibration sequencer
   // ************************************************************
   // fixed busy time; the analog end is not modelled, only its window
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         CAL_START  <= 1'b0;
         CAL_BUSY   <= 1'b0;
         cal_done_q <= 1'b0;
         cal_cnt_q  <= 16'h0000;
      end
      else
      begin
         CAL_START <= cal_rise;
         if (cal_rise)
         begin
            CAL_BUSY   <= 1'b1;
            cal_done_q <= 1'b0;
            cal_cnt_q  <= cal_len;
         end
         else if (CAL_BUSY)
         begin
            cal_cnt_q <= cal_cnt_q - 16'h0001;
            if (cal_cnt_q == 16'h0001)
            begin
               CAL_BUSY   <= 1'b0;
               cal_done_q <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_pd_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      upd_q |=> PLL_ASYNC_PD == ($past(stg_q.pwr) == PWR_ASYNC_PD)
                && PLL_ON == ($past(stg_q.pwr) == PWR_NORMAL))
      else $error("power-down output does not follow committed field");
   chk_bypass_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      upd_q |=> DIV_BYPASS == $past(stg_q.bypass))
      else $error("bypass output does not follow committed bit");
   chk_source_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      upd_q |=> SRC_VCO == $past(stg_q.src_vco))
      else $error("source output does not follow committed bit");
   chk_ratio_map: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      1'b1 |-> DIV_RATIO == act_q.div + DIV_OFFSET)
      else $error("divide ratio not field plus two");
   chk_pol_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      upd_q |=> PFD_NEG_POL == $past(stg_q.pfd_neg))
      else $error("polarity output does not follow committed bit");
   chk_cal_launch: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (upd_q && stg_q.cal && !act_q.cal) |=> CAL_START ##1 (CAL_BUSY && !CAL_START))
      else $error("calibration not launched on committed rise");
   chk_cal_rearm: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      CAL_START |-> $past(upd_q) && !$past(act_q.cal) && act_q.cal)
      else $error("calibration started without clear then set");
   chk_hold_uncommitted: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !upd_q |=> $stable(act_q) && $stable(SRC_VCO) && $stable(DIV_RATIO))
      else $error("active setting changed without update");
   chk_reset_default: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !seen_upd_q |-> act_q == CTRL_RST && PLL_ASYNC_PD && DIV_RATIO == 3'h4)
      else $error("defaults lost before first update");
   chk_update_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (upd_q && !w_upd) |=> !upd_q)
      else $error("update bit failed to clear itself");

   // pulse shape, exclusivity and whole-word commit
   chk_pll_exclusive: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !(PLL_ON && PLL_ASYNC_PD))
      else $error("PLL shown both running and powered down");
   chk_ratio_range: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (act_q.div <= 3'h4) |-> (DIV_RATIO >= 3'h2 && DIV_RATIO <= 3'h6))
      else $error("documented divider code gave ratio outside two to six");
   chk_start_pulse: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      CAL_START |=> !CAL_START)
      else $error("calibration start longer than one cycle");
   chk_start_busy: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      CAL_START |-> CAL_BUSY)
      else $error("calibration start without busy");
   chk_cal_done: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      $fell(CAL_BUSY) |-> cal_done_q)
      else $error("calibration end did not set done");
   chk_commit_whole: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      upd_q |=> act_q == $past(stg_q))
      else $error("active copy differs from committed staging");
   chk_update_value: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (wr_fire && widx == IDX_UPDATE && wb != UPDATE_CMD) |=> !upd_q)
      else $error("update flag raised by a value other than one");
   chk_reset_route: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !seen_upd_q |-> !PLL_ON && !SRC_VCO && !DIV_BYPASS && !PFD_NEG_POL)
      else $error("reset routing lost before first update");

endmodule

// file: pll_route_pkg.sv
package pll_route_pkg;
   // ************************************************************
   // register indices; byte address is four times the index
   // ************************************************************
   localparam logic [9:0]  IDX_PWR_POL   = 10'h010;
   localparam logic [9:0]  IDX_CAL_CTRL  = 10'h018;
   localparam logic [9:0]  IDX_DIV_RATIO = 10'h1e0;
   localparam logic [9:0]  IDX_SRC_SEL   = 10'h1e1;
   localparam logic [9:0]  IDX_UPDATE    = 10'h232;
   localparam logic [9:0]  IDX_STATUS    = 10'h233;
   localparam int          ADDR_W        = 12;

   // ************************************************************
   // field values and reset values
   // ************************************************************
   localparam logic [1:0]  PWR_NORMAL    = 2'h0;
   localparam logic [1:0]  PWR_ASYNC_PD  = 2'h1;
   localparam logic [2:0]  DIV_RST       = 3'h2;
   localparam logic [2:0]  DIV_OFFSET    = 3'h2;
   localparam logic [7:0]  UPDATE_CMD    = 8'h01;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam int          CAL_CYCLES    = 16;

   // settings held both staged and active
   typedef struct packed {
      logic       pfd_neg;
      logic [1:0] pwr;
      logic       cal;
      logic [2:0] div;
      logic       src_vco;
      logic       bypass;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{pfd_neg: 1'b0, pwr: PWR_ASYNC_PD, cal: 1'b0,
                                  div: DIV_RST, src_vco: 1'b0, bypass: 1'b0};
endpackage
